// file: hdl/aofr_pkg.sv
package aofr_pkg;
  localparam int           CLK_FREQ_HZ  = 20_000_000;
  localparam int           TICK_MS      = 1;
  localparam int           TICK_CYCLES  = CLK_FREQ_HZ / 1000 * TICK_MS;
  localparam int           NUM_CH       = 2;

  localparam logic [7:0]   ADDR_CTRL    = 8'h00;
  localparam logic [7:0]   ADDR_FBVAL0  = 8'h04;
  localparam logic [7:0]   ADDR_FBVAL1  = 8'h08;
  localparam logic [7:0]   ADDR_PERIOD  = 8'h0c;
  localparam logic [7:0]   ADDR_STATUS  = 8'h10;

  localparam int           CTRL_MODE_LSB  = 0;
  localparam int           CTRL_SCALE_LSB = 4;
  localparam logic [1:0]   MODE_RESET   = 2'h0;
  localparam logic [2:0]   SCALE_RESET  = 3'h0;
  localparam logic [15:0]  FBVAL_RESET  = 16'h0000;
  localparam logic [7:0]   PERIOD_RESET = 8'h0a;
  localparam logic [7:0]   PERIOD_MIN   = 8'h05;

  localparam logic [7:0]   PRM_LEN      = 8'h01;
  localparam logic [7:0]   PRM_IDX_LO   = 8'h10;
  localparam logic [7:0]   PRM_IDX_HI   = 8'h23;
  localparam logic [7:0]   PRM_SUBIDX   = 8'h00;

  localparam logic signed [15:0] FB_MIN_1_5 = -16'sd768;

  typedef enum logic [2:0] {
    SCALE_1_5  = 3'h0,
    SCALE_0_5  = 3'h1,
    SCALE_0_10 = 3'h2,
    SCALE_PM5  = 3'h3,
    SCALE_PM10 = 3'h4
  } aofr_scale_t;

  function automatic logic aofr_in_range(input logic [2:0] sc, input logic signed [15:0] v);
    case (sc)
      SCALE_1_5:             return v >= FB_MIN_1_5;
      SCALE_0_5, SCALE_0_10: return !v[15];
      SCALE_PM5, SCALE_PM10: return 1'b1;
      default:               return 1'b0;
    endcase
  endfunction
endpackage

// file: hdl/aofr_chan.sv
`timescale 1ns/100ps
`default_nettype none
module aofr_chan
  import aofr_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ms_tick,
  input  wire logic [7:0]  period,
  input  wire logic        comm_ok,
  input  wire logic        upd_valid,
  input  wire logic [15:0] upd_data,
  input  wire logic        mode_hold,
  input  wire logic [15:0] fb_count,
  output logic [15:0]      dac_data,
  output logic             dac_write,
  output logic             in_fallback
);
  typedef enum logic {ST_RUN, ST_FALLBACK} aofr_chst_t;
  aofr_chst_t  st_reg;
  logic [15:0] last_rx_reg;
  logic [7:0]  age_reg;
  logic        refresh;

  assign refresh = ms_tick && (age_reg + 8'h01 >= period);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_rx_reg <= 16'h0000;
    end else if (upd_valid) begin
      last_rx_reg <= upd_data;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_reg    <= ST_RUN;
      dac_data  <= 16'h0000;
      dac_write <= 1'b0;
      age_reg   <= 8'h00;
    end else begin
      dac_write <= 1'b0;
      age_reg   <= ms_tick ? age_reg + 8'h01 : age_reg;
      case (st_reg)
        ST_RUN: begin
          if (!comm_ok) begin
            st_reg    <= ST_FALLBACK;
            dac_write <= 1'b1;
            age_reg   <= 8'h00;
            if (!mode_hold) begin
              dac_data <= fb_count;
            end
          end else if (upd_valid) begin
            dac_data  <= upd_data;
            dac_write <= 1'b1;
            age_reg   <= 8'h00;
          end else if (refresh) begin
            dac_write <= 1'b1;
            age_reg   <= 8'h00;
          end
        end
        ST_FALLBACK: begin
          if (comm_ok) begin
            st_reg    <= ST_RUN;
            dac_data  <= upd_valid ? upd_data : last_rx_reg;
            dac_write <= 1'b1;
            age_reg   <= 8'h00;
          end else if (refresh) begin
            dac_write <= 1'b1;
            age_reg   <= 8'h00;
          end
        end
        default: st_reg <= ST_RUN;
      endcase
    end
  end

  assign in_fallback = (st_reg == ST_FALLBACK);

  a_refresh_due: assert property (@(posedge pclk) disable iff (!presetn)
    refresh |=> dac_write)
    else $error("refresh not issued");
  a_fb_entry: assert property (@(posedge pclk) disable iff (!presetn)
    (st_reg == ST_RUN && !comm_ok && !mode_hold) |=> in_fallback && dac_data == $past(fb_count))
    else $error("fallback value not applied");
  a_hold_steady: assert property (@(posedge pclk) disable iff (!presetn)
    (in_fallback && !comm_ok) |=> $stable(dac_data))
    else $error("held value changed");
  a_restore_data: assert property (@(posedge pclk) disable iff (!presetn)
    (in_fallback && comm_ok && !upd_valid) |=> !in_fallback && dac_data == $past(last_rx_reg))
    else $error("restore did not drive last data");
  c_fallback: cover property (@(posedge pclk) disable iff (!presetn)
    in_fallback ##1 !in_fallback);
  c_refresh: cover property (@(posedge pclk) disable iff (!presetn)
    refresh && !in_fallback);
endmodule
`default_nettype wire

// file: hdl/aofr_top.sv
`timescale 1ns/100ps
`default_nettype none
module aofr_top
  import aofr_pkg::*;
#(
  parameter int MS_CYCLES = TICK_CYCLES
)
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [7:0]  paddr,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        prm_req_valid,
  input  wire logic        prm_req_write,
  input  wire logic [7:0]  prm_req_len,
  input  wire logic [7:0]  prm_req_idx_lo,
  input  wire logic [7:0]  prm_req_idx_hi,
  input  wire logic [7:0]  prm_req_subidx,
  input  wire logic [7:0]  prm_req_data,
  output logic             prm_resp_valid,
  output logic             prm_resp_ok,
  output logic [7:0]       prm_resp_data,
  input  wire logic        comm_ok,
  input  wire logic        out_valid0,
  input  wire logic [15:0] out_data0,
  input  wire logic        out_valid1,
  input  wire logic [15:0] out_data1,
  output logic [15:0]      dac_data0,
  output logic             dac_write0,
  output logic [15:0]      dac_data1,
  output logic             dac_write1,
  output logic [1:0]       fallback_active
);
  logic [1:0]  mode_hold_reg;
  logic [2:0]  scale_reg;
  logic [15:0] fbval_reg [NUM_CH];
  logic [15:0] fb_count  [NUM_CH];
  logic [7:0]  period_reg;
  logic [1:0]  comm_sync_reg;
  logic [15:0] tick_cnt_reg;
  logic        ms_tick_reg;
  logic        wr_en;
  logic        rd_en;
  logic        prm_match;
  logic        prm_wr_ok;
  logic [1:0]  mode_next;
  logic [15:0] dac_data  [NUM_CH];
  logic [1:0]  dac_write;
  logic [1:0]  in_fb;
  logic        upd_valid [NUM_CH];
  logic [15:0] upd_data  [NUM_CH];

  assign wr_en = psel && penable && pwrite && pready;
  assign rd_en = psel && !penable && !pwrite;
  assign prm_match = prm_req_len == PRM_LEN && prm_req_idx_lo == PRM_IDX_LO
                  && prm_req_idx_hi == PRM_IDX_HI && prm_req_subidx == PRM_SUBIDX;
  assign prm_wr_ok = prm_req_valid && prm_req_write && prm_match
                  && prm_req_data >= PERIOD_MIN;
  assign mode_next = (wr_en && paddr == ADDR_CTRL) ? pwdata[CTRL_MODE_LSB +: 2] : mode_hold_reg;

  function automatic logic addr_mapped(input logic [7:0] a);
    return a == ADDR_CTRL || a == ADDR_FBVAL0 || a == ADDR_FBVAL1
        || a == ADDR_PERIOD || a == ADDR_STATUS;
  endfunction

  // Loss of link comes from outside this clock
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      comm_sync_reg <= 2'b00;
    end else begin
      comm_sync_reg <= {comm_sync_reg[0], comm_ok};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt_reg <= 16'h0000;
      ms_tick_reg  <= 1'b0;
    end else if (tick_cnt_reg == 16'(MS_CYCLES - 1)) begin
      tick_cnt_reg <= 16'h0000;
      ms_tick_reg  <= 1'b1;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 16'h0001;
      ms_tick_reg  <= 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && !penable;
      pslverr <= psel && !penable && !addr_mapped(paddr);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (rd_en) begin
      case (paddr)
        ADDR_CTRL:   prdata <= {25'h0, scale_reg, 2'h0, mode_hold_reg};
        ADDR_FBVAL0: prdata <= {16'h0, fbval_reg[0]};
        ADDR_FBVAL1: prdata <= {16'h0, fbval_reg[1]};
        ADDR_PERIOD: prdata <= {24'h0, period_reg};
        ADDR_STATUS: prdata <= {29'h0, in_fb, comm_sync_reg[1]};
        default:     prdata <= 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_hold_reg <= MODE_RESET;
      scale_reg     <= SCALE_RESET;
    end else if (wr_en && paddr == ADDR_CTRL) begin
      mode_hold_reg <= pwdata[CTRL_MODE_LSB +: 2];
      scale_reg     <= pwdata[CTRL_SCALE_LSB +: 3];
    end
  end

  for (genvar i = 0; i < NUM_CH; i++) begin : g_fb
    logic [7:0] fb_addr;
    assign fb_addr = (i == 0) ? ADDR_FBVAL0 : ADDR_FBVAL1;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        fbval_reg[i] <= FBVAL_RESET;
      end else if (mode_next[i]) begin
        fbval_reg[i] <= 16'h0000;
      end else if (wr_en && paddr == fb_addr) begin
        fbval_reg[i] <= pwdata[15:0];
      end
    end
    assign fb_count[i] = aofr_in_range(scale_reg, fbval_reg[i]) ? fbval_reg[i] : 16'h0000;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      period_reg <= PERIOD_RESET;
    end else if (prm_wr_ok) begin
      period_reg <= prm_req_data;
    end else if (wr_en && paddr == ADDR_PERIOD && pwdata[7:0] >= PERIOD_MIN) begin
      period_reg <= pwdata[7:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prm_resp_valid <= 1'b0;
      prm_resp_ok    <= 1'b0;
      prm_resp_data  <= 8'h00;
    end else begin
      prm_resp_valid <= prm_req_valid;
      prm_resp_ok    <= prm_req_valid && prm_match
                     && (!prm_req_write || prm_req_data >= PERIOD_MIN);
      prm_resp_data  <= prm_req_valid ? period_reg : 8'h00;
    end
  end

  assign upd_valid[0] = out_valid0;
  assign upd_valid[1] = out_valid1;
  assign upd_data[0]  = out_data0;
  assign upd_data[1]  = out_data1;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
    aofr_chan u_chan (
      .pclk        (pclk),
      .presetn     (presetn),
      .ms_tick     (ms_tick_reg),
      .period      (period_reg),
      .comm_ok     (comm_sync_reg[1]),
      .upd_valid   (upd_valid[i]),
      .upd_data    (upd_data[i]),
      .mode_hold   (mode_hold_reg[i]),
      .fb_count    (fb_count[i]),
      .dac_data    (dac_data[i]),
      .dac_write   (dac_write[i]),
      .in_fallback (in_fb[i])
    );
  end

  assign dac_data0       = dac_data[0];
  assign dac_data1       = dac_data[1];
  assign dac_write0      = dac_write[0];
  assign dac_write1      = dac_write[1];
  assign fallback_active = in_fb;

  a_period_range: assert property (@(posedge pclk) disable iff (!presetn)
    period_reg >= PERIOD_MIN)
    else $error("period below minimum");
  a_prm_write: assert property (@(posedge pclk) disable iff (!presetn)
    prm_wr_ok |=> period_reg == $past(prm_req_data) && prm_resp_valid && prm_resp_ok)
    else $error("parameter write not taken");
  a_hold_zero: assert property (@(posedge pclk) disable iff (!presetn)
    mode_hold_reg[0] |-> fbval_reg[0] == 16'h0000)
    else $error("hold channel value not zero");
  a_range_zero: assert property (@(posedge pclk) disable iff (!presetn)
    !aofr_in_range(scale_reg, fbval_reg[1]) |-> fb_count[1] == 16'h0000)
    else $error("out of range value applied");
  a_apb_ready: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && !penable) |=> pready ##1 !pready)
    else $error("ready timing wrong");
  c_prm_ok: cover property (@(posedge pclk) disable iff (!presetn) prm_wr_ok);
  c_hold_mode: cover property (@(posedge pclk) disable iff (!presetn)
    mode_hold_reg[1] && in_fb[1]);
endmodule
`default_nettype wire

// file: tb/aofr_niu_model.sv
`timescale 1ns/100ps
`default_nettype none
module aofr_niu_model (
  input  wire logic   pclk,
  output logic        comm_ok,
  output logic        out_valid0,
  output logic [15:0] out_data0,
  output logic        out_valid1,
  output logic [15:0] out_data1
);
  initial begin
    comm_ok = 1'b0;
    out_valid0 = 1'b0;
    out_valid1 = 1'b0;
    out_data0 = 16'h0000;
    out_data1 = 16'h0000;
  end
  // Released data shows the inverse of the last word
  task automatic send(input int ch, input logic [15:0] v);
    @(posedge pclk);
    out_valid0 <= (ch == 0);
    out_valid1 <= (ch == 1);
    out_data0 <= (ch == 0) ? v : ~out_data0;
    out_data1 <= (ch == 1) ? v : ~out_data1;
    @(posedge pclk);
    out_valid0 <= 1'b0;
    out_valid1 <= 1'b0;
    out_data0 <= ~out_data0;
    out_data1 <= ~out_data1;
    repeat (2) @(posedge pclk);
  endtask
  task automatic link(input logic up);
    @(posedge pclk);
    comm_ok <= up;
  endtask
endmodule
`default_nettype wire

// file: tb/aofr_top_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module aofr_top_tb_top;
  import aofr_pkg::*;
  localparam int MSC = 20;
  typedef struct packed {
    logic       wr;
    logic [7:0] len, lo, hi, sub, dat;
    logic       ok;
  } aofr_row_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00, prm_req_len = 8'h00, prm_req_idx_lo = 8'h00;
  logic [7:0] prm_req_idx_hi = 8'h00, prm_req_subidx = 8'h00, prm_req_data = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, r;
  logic prm_req_valid = 1'b0, prm_req_write = 1'b0, pready, pslverr, e;
  logic prm_resp_valid, prm_resp_ok, comm_ok, out_valid0, out_valid1, dac_write0, dac_write1;
  logic [7:0] prm_resp_data, per;
  logic [15:0] out_data0, out_data1, dac_data0, dac_data1;
  logic [1:0] fallback_active;
  int fails = 0, n_tests = 0, n;
  aofr_row_t rows [9] = '{
    '{1'b0, 8'h01, 8'h10, 8'h23, 8'h00, 8'h00, 1'b1}, '{1'b1, 8'h01, 8'h10, 8'h23, 8'h00, 8'h05, 1'b1},
    '{1'b1, 8'h01, 8'h10, 8'h23, 8'h00, 8'h04, 1'b0}, '{1'b1, 8'h01, 8'h10, 8'h23, 8'h00, 8'hff, 1'b1},
    '{1'b0, 8'h01, 8'h11, 8'h23, 8'h00, 8'h00, 1'b0}, '{1'b0, 8'h01, 8'h10, 8'h24, 8'h00, 8'h00, 1'b0},
    '{1'b0, 8'h01, 8'h10, 8'h23, 8'h01, 8'h00, 1'b0}, '{1'b1, 8'h02, 8'h10, 8'h23, 8'h00, 8'h07, 1'b0},
    '{1'b1, 8'h01, 8'h10, 8'h23, 8'h00, 8'h05, 1'b1}};

  always #25 pclk = ~pclk;

  aofr_top #(.MS_CYCLES(MSC)) i_aofr_top (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
    .pwdata, .prdata, .pready, .pslverr, .prm_req_valid, .prm_req_write, .prm_req_len,
    .prm_req_idx_lo, .prm_req_idx_hi, .prm_req_subidx, .prm_req_data, .prm_resp_valid,
    .prm_resp_ok, .prm_resp_data, .comm_ok, .out_valid0, .out_data0, .out_valid1, .out_data1,
    .dac_data0, .dac_write0, .dac_data1, .dac_write1, .fallback_active);
  aofr_niu_model i_aofr_niu_model (.pclk, .comm_ok, .out_valid0, .out_data0, .out_valid1,
    .out_data1);

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    n_tests++;
    if (g !== x) begin
      $display("BAD t=%0t got=%h exp=%h", $time, g, x);
      fails++;
    end
  endtask
  task automatic tmo();
    fails++;
    complete_run();
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      k++;
      if (k > 20) tmo();
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(r, x);
  endtask
  task automatic prm(input aofr_row_t q);
    @(posedge pclk);
    prm_req_valid <= 1'b1;
    prm_req_write <= q.wr;
    prm_req_len <= q.len;
    prm_req_idx_lo <= q.lo;
    prm_req_idx_hi <= q.hi;
    prm_req_subidx <= q.sub;
    prm_req_data <= q.dat;
    @(posedge pclk);
    prm_req_valid <= 1'b0;
    prm_req_data <= ~q.dat;
    #1;
    chk(prm_resp_valid, 1'b1);
    chk(prm_resp_ok, q.ok);
    if (q.ok) chk(prm_resp_data, per);
    if (q.ok && q.wr) per = q.dat;
  endtask
  task automatic wait_fb(input logic [1:0] x);
    int k;
    k = 0;
    while (fallback_active !== x) begin
      @(posedge pclk);
      #1;
      k++;
      if (k > 10) tmo();
    end
  endtask
  task automatic link(input logic up);
    i_aofr_niu_model.link(up);
    wait_fb(up ? 2'b00 : 2'b11);
  endtask
  task automatic wait_wr(output int k);
    k = 0;
    do begin
      @(posedge pclk);
      #1;
      k++;
      if (k > 200) tmo();
    end while (dac_write0 !== 1'b1);
  endtask

  initial begin
    per = PERIOD_RESET;
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i]) prm(rows[i]);
    rd(ADDR_PERIOD, 32'h5);
    apb(1'b1, ADDR_PERIOD, 32'h4);
    rd(ADDR_PERIOD, 32'h5);
    apb(1'b1, 8'h20, 32'h1);
    chk(e, 1'b1);
    $display("test param done");
    wait_fb(2'b11);
    chk(dac_data0, 16'h0);
    link(1'b1);
    i_aofr_niu_model.send(0, 16'h0100);
    i_aofr_niu_model.send(1, 16'h0200);
    chk(dac_data0, 16'h0100);
    link(1'b0);
    chk({dac_data0, dac_data1}, 32'h0);
    chk(dac_write1, 1'b1);
    i_aofr_niu_model.send(0, 16'h0300);
    chk(dac_data0, 16'h0);
    link(1'b1);
    chk({dac_data0, dac_data1}, 32'h03000200);
    $display("test fallback done");
    apb(1'b1, ADDR_FBVAL0, 32'hfd00);
    apb(1'b1, ADDR_FBVAL1, 32'hfcff);
    link(1'b0);
    chk(dac_data0, 16'hfd00);
    chk(dac_data1, 16'h0);
    link(1'b1);
    $display("test predefined done");
    i_aofr_niu_model.send(1, 16'h0777);
    apb(1'b1, ADDR_CTRL, 32'h2);
    rd(ADDR_FBVAL1, 32'h0);
    apb(1'b1, ADDR_FBVAL1, 32'h55);
    rd(ADDR_FBVAL1, 32'h0);
    link(1'b0);
    chk({dac_data0, dac_data1}, 32'hfd000777);
    link(1'b1);
    $display("test hold done");
    apb(1'b1, ADDR_CTRL, 32'h10);
    link(1'b0);
    chk({dac_data0, dac_data1}, 32'h0);
    rd(ADDR_STATUS, 32'h6);
    link(1'b1);
    rd(ADDR_STATUS, 32'h1);
    apb(1'b1, ADDR_CTRL, 32'h1);
    rd(ADDR_FBVAL0, 32'h0);
    $display("test scale done");
    wait_wr(n);
    wait_wr(n);
    chk(n >= 4 * MSC && n <= 5 * MSC + 2, 1'b1);
    chk(dac_data0, 16'h0300);
    $display("test refresh done");
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(ADDR_PERIOD, 32'h0a);
    rd(ADDR_CTRL, 32'h0);
    $display("test reset done");
    complete_run();
  end
endmodule
`default_nettype wire
